// [core/bpsc_defines.svh]
// Purpose: Constants for the burst preamble status capture block.
// Assumes: Sixteen-bit preamble words arrive one per strobe.
// Notes:   Definitions only.
`ifndef BPSC_DEFINES_SVH
`define BPSC_DEFINES_SVH

// ****************************************************************
// Synchronising preamble words
// ****************************************************************
`define BPSC_SYNC_FIRST      16'hF872
`define BPSC_SYNC_SECOND     16'h4E1F

// ****************************************************************
// Register addresses
// ****************************************************************
`define BPSC_ADDR_TYPE_HIGH  8'h29
`define BPSC_ADDR_TYPE_LOW   8'h2A
`define BPSC_ADDR_LEN_HIGH   8'h2B
`define BPSC_ADDR_LEN_LOW    8'h2C
`define BPSC_RESET_BYTE      8'h00
`define BPSC_RESET_WORD      16'h0000

// ****************************************************************
// Type word fields
// ****************************************************************
`define BPSC_TYPE_CODE       4:0
`define BPSC_ZERO_FIELD      6:5
`define BPSC_ERROR_BIT       7
`define BPSC_DEPENDENT       12:8
`define BPSC_STREAM          15:13
`define BPSC_ZERO_PAIR       2'h0
`define BPSC_STREAM_ZERO     3'h0

// ****************************************************************
// Payload type codes
// ****************************************************************
`define BPSC_CODE_NULL       5'h00
`define BPSC_CODE_RSV_A      5'h02
`define BPSC_CODE_PAUSE      5'h03
`define BPSC_CODE_MPEG_FIRST 5'h04
`define BPSC_CODE_MPEG_L23   5'h05
`define BPSC_CODE_MPEG_L1LS  5'h08
`define BPSC_CODE_MPEG_LAST  5'h09
`define BPSC_CODE_RSV_B      5'h0A
`define BPSC_CODE_RSV_HIGH   5'h10

`endif

// [core/bpsc_pkg.sv]
// Purpose: Types for the burst preamble status capture block.
// Assumes: Constants come from bpsc_defines.svh.
// Notes:   No logic here.
package bpsc_pkg;

  typedef enum logic [2:0] {
    WAIT_FIRST,
    WAIT_SECOND,
    TAKE_TYPE,
    TAKE_LENGTH
  } bpsc_state_e;

  typedef enum logic [2:0] {
    CLASS_NULL,
    CLASS_PAUSE,
    CLASS_MPEG,
    CLASS_MPEG_LOW_RATE,
    CLASS_RESERVED,
    CLASS_OTHER
  } bpsc_class_e;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } bpsc_word_s;

  typedef struct packed {
    logic [15:0] type_word;
    logic [15:0] length_word;
  } bpsc_preamble_s;

endpackage : bpsc_pkg

// [core/bpsc_capture.sv]
// Purpose: Finds compressed-audio burst headers in the received word
//          stream and holds their type and length words for reading.
// Assumes: One recovered sixteen-bit word per strobe, synchronous to clk.
// Notes:   Reads have one cycle of latency and no side effects.
//
// Notes on behaviour
// [R1] A burst begins where the word 0xF872 is followed by 0x4E1F.
// [R2] The third header word is taken as the payload type descriptor.
// [R3] The fourth header word is taken as the payload length in bits.
// [R4] Both words are readable as four read-only bytes at 0x29 to 0x2C.
// [R5] Type codes 04 to 09 are MPEG variants, 05 being layer 2/3 plain.
// [R6] Code 08 is layer 1 and code 09 layer 2/3, both at low rate.
// [R7] Type word bits 6 and 5 always read as zero.
// [R8] Type word bit 7 marks a payload that may hold errors.
// [R9] Type word bits 12 to 8 pass through unchanged.
// [R10] Type word bits 15 to 13 hold the stream number, expected zero.
// [R11] Length high byte reads at 0x2B and low byte at 0x2C.
// [R12] All four bytes change together when a header completes.
// [R13] Codes 00 and 03 are null and pause; 02, 0A, 10-1F are reserved.
`timescale 1ns/10ps
`include "bpsc_defines.svh"

module bpsc_capture (
  input  wire logic                 clk,            // 250 MHz clock
  input  wire logic                 reset,          // Sync, active high
  input  wire bpsc_pkg::bpsc_word_s rx_word,        // Recovered word
  input  wire logic                 rd_en,          // Read strobe
  input  wire logic [7:0]           rd_addr,        // Register address
  output logic [7:0]                rd_data,        // Read data
  output logic                      rd_valid,       // Read data strobe
  output logic                      burst_new,      // Header captured
  output bpsc_pkg::bpsc_class_e     burst_class,    // Payload class
  output logic                      burst_error,    // Payload suspect
  output logic                      stream_nonzero  // Stream not zero
);

  // ****************************************************************
  // Header recognition
  // ****************************************************************
  bpsc_pkg::bpsc_state_e    state_reg;
  bpsc_pkg::bpsc_preamble_s pre_reg;
  logic [15:0]              type_hold_reg;
  logic                     take_length;

  assign take_length = rx_word.valid &&
                       (state_reg == bpsc_pkg::TAKE_LENGTH);

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= bpsc_pkg::WAIT_FIRST;
    end else if (rx_word.valid) begin
      case (state_reg)
        bpsc_pkg::WAIT_FIRST: begin
          if (rx_word.data == `BPSC_SYNC_FIRST) begin // R1
            state_reg <= bpsc_pkg::WAIT_SECOND;
          end
        end
        bpsc_pkg::WAIT_SECOND: begin
          // A repeated first sync word may itself start the header.
          if (rx_word.data == `BPSC_SYNC_SECOND) begin // R1
            state_reg <= bpsc_pkg::TAKE_TYPE;
          end else if (rx_word.data != `BPSC_SYNC_FIRST) begin
            state_reg <= bpsc_pkg::WAIT_FIRST;
          end
        end
        bpsc_pkg::TAKE_TYPE:   state_reg <= bpsc_pkg::TAKE_LENGTH;
        bpsc_pkg::TAKE_LENGTH: state_reg <= bpsc_pkg::WAIT_FIRST;
        default:               state_reg <= bpsc_pkg::WAIT_FIRST;
      endcase
    end
  end

  // The type word is held aside until the length arrives, so a reader
  // never sees the type of one burst beside the length of another.
  always_ff @(posedge clk) begin
    if (reset) begin
      type_hold_reg <= `BPSC_RESET_WORD;
    end else if (rx_word.valid && state_reg == bpsc_pkg::TAKE_TYPE) begin
      type_hold_reg <= rx_word.data; // R2 R9 R10
      type_hold_reg[`BPSC_ZERO_FIELD] <= `BPSC_ZERO_PAIR; // R7
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pre_reg <= '0;
    end else if (take_length) begin
      pre_reg.type_word   <= type_hold_reg; // R12
      pre_reg.length_word <= rx_word.data; // R3 R12
    end
  end

  // ****************************************************************
  // Payload classification
  // ****************************************************************
  // Codes above the MPEG range that are not reserved stay in OTHER, so
  // a payload family unknown to the host never passes for MPEG audio.
  function automatic bpsc_pkg::bpsc_class_e classify(
    input logic [4:0] code
  );
    bpsc_pkg::bpsc_class_e c;
    c = bpsc_pkg::CLASS_OTHER;
    if (code == `BPSC_CODE_NULL) begin
      c = bpsc_pkg::CLASS_NULL; // R13
    end else if (code == `BPSC_CODE_PAUSE) begin
      c = bpsc_pkg::CLASS_PAUSE; // R13
    end else if (code == `BPSC_CODE_RSV_A || code == `BPSC_CODE_RSV_B ||
                 code >= `BPSC_CODE_RSV_HIGH) begin
      c = bpsc_pkg::CLASS_RESERVED; // R13
    end else if (code >= `BPSC_CODE_MPEG_L1LS &&
                 code <= `BPSC_CODE_MPEG_LAST) begin
      c = bpsc_pkg::CLASS_MPEG_LOW_RATE; // R6
    end else if (code >= `BPSC_CODE_MPEG_FIRST &&
                 code < `BPSC_CODE_MPEG_L1LS) begin
      c = bpsc_pkg::CLASS_MPEG; // R5
    end
    return c;
  endfunction : classify

  always_ff @(posedge clk) begin
    if (reset) begin
      burst_new      <= 1'b0;
      burst_class    <= bpsc_pkg::CLASS_NULL;
      burst_error    <= 1'b0;
      stream_nonzero <= 1'b0;
    end else begin
      burst_new <= take_length;
      if (take_length) begin
        burst_class    <= classify(type_hold_reg[`BPSC_TYPE_CODE]);
        burst_error    <= type_hold_reg[`BPSC_ERROR_BIT]; // R8
        stream_nonzero <= type_hold_reg[`BPSC_STREAM] !=
                          `BPSC_STREAM_ZERO; // R10
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data  <= `BPSC_RESET_BYTE;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        case (rd_addr) // R4
          `BPSC_ADDR_TYPE_HIGH: rd_data <= pre_reg.type_word[15:8];
          `BPSC_ADDR_TYPE_LOW:  rd_data <= pre_reg.type_word[7:0];
          `BPSC_ADDR_LEN_HIGH:  rd_data <= pre_reg.length_word[15:8]; // R11
          `BPSC_ADDR_LEN_LOW:   rd_data <= pre_reg.length_word[7:0]; // R11
          default:              rd_data <= `BPSC_RESET_BYTE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_sync_pair_seen: assert property ( // R1
    (rx_word.valid && state_reg == bpsc_pkg::WAIT_SECOND &&
     rx_word.data == `BPSC_SYNC_SECOND)
    |=> state_reg == bpsc_pkg::TAKE_TYPE)
    else $error("second sync word did not open the header");

  a_no_false_sync: assert property ( // R1
    (rx_word.valid && state_reg == bpsc_pkg::WAIT_FIRST &&
     rx_word.data != `BPSC_SYNC_FIRST)
    |=> state_reg == bpsc_pkg::WAIT_FIRST)
    else $error("header opened without first sync word");

  a_type_taken: assert property ( // R2
    (rx_word.valid && state_reg == bpsc_pkg::TAKE_TYPE)
    |=> type_hold_reg[`BPSC_DEPENDENT] ==
        $past(rx_word.data[`BPSC_DEPENDENT]) &&
        type_hold_reg[`BPSC_STREAM] == $past(rx_word.data[`BPSC_STREAM]))
    else $error("type word not taken from third header word");

  a_length_taken: assert property ( // R3
    take_length |=> pre_reg.length_word == $past(rx_word.data) &&
                    pre_reg.type_word == $past(type_hold_reg))
    else $error("header words not captured together");

  a_zero_field: assert property ( // R7
    pre_reg.type_word[`BPSC_ZERO_FIELD] == `BPSC_ZERO_PAIR)
    else $error("type word bits 6 and 5 not zero");

  a_error_flag: assert property ( // R8
    burst_new |-> burst_error == pre_reg.type_word[`BPSC_ERROR_BIT])
    else $error("error flag differs from captured bit 7");

  a_low_rate: assert property ( // R6
    burst_new && (pre_reg.type_word[`BPSC_TYPE_CODE] == `BPSC_CODE_MPEG_L1LS
    || pre_reg.type_word[`BPSC_TYPE_CODE] == `BPSC_CODE_MPEG_LAST)
    |-> burst_class == bpsc_pkg::CLASS_MPEG_LOW_RATE)
    else $error("low rate code misclassified");

  a_mpeg_plain: assert property ( // R5
    burst_new &&
    pre_reg.type_word[`BPSC_TYPE_CODE] == `BPSC_CODE_MPEG_L23
    |-> burst_class == bpsc_pkg::CLASS_MPEG)
    else $error("layer 2/3 code not classed as MPEG");

  a_len_high_read: assert property ( // R11
    rd_en && rd_addr == `BPSC_ADDR_LEN_HIGH
    |=> rd_valid && rd_data == $past(pre_reg.length_word[15:8]))
    else $error("length high byte read wrong");

  a_type_low_read: assert property ( // R4
    rd_en && rd_addr == `BPSC_ADDR_TYPE_LOW
    |=> rd_valid && rd_data == $past(pre_reg.type_word[7:0]))
    else $error("type low byte read wrong");

  a_stable_between: assert property ( // R12
    !take_length |=> $stable(pre_reg))
    else $error("capture changed without a header");

  a_repeat_first: assert property ( // R1
    (rx_word.valid && state_reg == bpsc_pkg::WAIT_SECOND &&
     rx_word.data == `BPSC_SYNC_FIRST)
    |=> state_reg == bpsc_pkg::WAIT_SECOND)
    else $error("repeated first sync word lost the header");

  a_type_to_length: assert property ( // R2
    (rx_word.valid && state_reg == bpsc_pkg::TAKE_TYPE)
    |=> state_reg == bpsc_pkg::TAKE_LENGTH)
    else $error("type word did not lead to the length word");

  a_new_after_length: assert property ( // R12
    take_length |=> burst_new)
    else $error("header capture not flagged");

  a_new_one_cycle: assert property ( // R12
    burst_new |=> !burst_new)
    else $error("header flag longer than one cycle");

  a_stream_flag: assert property ( // R10
    burst_new |-> stream_nonzero ==
      (pre_reg.type_word[`BPSC_STREAM] != `BPSC_STREAM_ZERO))
    else $error("stream flag differs from captured stream bits");

  a_null_class: assert property ( // R13
    burst_new &&
    pre_reg.type_word[`BPSC_TYPE_CODE] == `BPSC_CODE_NULL
    |-> burst_class == bpsc_pkg::CLASS_NULL)
    else $error("null code misclassified");

  a_pause_class: assert property ( // R13
    burst_new &&
    pre_reg.type_word[`BPSC_TYPE_CODE] == `BPSC_CODE_PAUSE
    |-> burst_class == bpsc_pkg::CLASS_PAUSE)
    else $error("pause code misclassified");

  a_reserved_class: assert property ( // R13
    burst_new &&
    (pre_reg.type_word[`BPSC_TYPE_CODE] == `BPSC_CODE_RSV_A ||
     pre_reg.type_word[`BPSC_TYPE_CODE] == `BPSC_CODE_RSV_B ||
     pre_reg.type_word[`BPSC_TYPE_CODE] >= `BPSC_CODE_RSV_HIGH)
    |-> burst_class == bpsc_pkg::CLASS_RESERVED)
    else $error("reserved code misclassified");

  a_mpeg_range: assert property ( // R5
    burst_new &&
    pre_reg.type_word[`BPSC_TYPE_CODE] >= `BPSC_CODE_MPEG_FIRST &&
    pre_reg.type_word[`BPSC_TYPE_CODE] < `BPSC_CODE_MPEG_L1LS
    |-> burst_class == bpsc_pkg::CLASS_MPEG)
    else $error("MPEG code misclassified");

  a_mpeg_bounded: assert property ( // R5
    burst_new && burst_class == bpsc_pkg::CLASS_MPEG
    |-> pre_reg.type_word[`BPSC_TYPE_CODE] >= `BPSC_CODE_MPEG_FIRST &&
        pre_reg.type_word[`BPSC_TYPE_CODE] < `BPSC_CODE_MPEG_L1LS)
    else $error("non-MPEG code classed as MPEG");

  a_type_high_read: assert property ( // R4
    rd_en && rd_addr == `BPSC_ADDR_TYPE_HIGH
    |=> rd_valid && rd_data == $past(pre_reg.type_word[15:8]))
    else $error("type high byte read wrong");

  a_len_low_read: assert property ( // R11
    rd_en && rd_addr == `BPSC_ADDR_LEN_LOW
    |=> rd_valid && rd_data == $past(pre_reg.length_word[7:0]))
    else $error("length low byte read wrong");

  a_unmapped_read: assert property ( // R4
    rd_en &&
    (rd_addr < `BPSC_ADDR_TYPE_HIGH || rd_addr > `BPSC_ADDR_LEN_LOW)
    |=> rd_data == `BPSC_RESET_BYTE)
    else $error("unmapped address did not read zero");

  a_read_strobe: assert property ( // R4
    rd_en |=> rd_valid)
    else $error("read strobe not answered");

  a_read_quiet: assert property ( // R4
    !rd_en |=> !rd_valid)
    else $error("read data strobe without a read");

  a_read_hold: assert property ( // R4
    !rd_en |=> $stable(rd_data))
    else $error("read data changed without a read");

  c_header_seen:  cover property (burst_new);
  c_mpeg_burst:   cover property (burst_new &&
                                  burst_class == bpsc_pkg::CLASS_MPEG);
  c_error_burst:  cover property (burst_new && burst_error);
  c_length_read:  cover property (rd_en &&
                                  rd_addr == `BPSC_ADDR_LEN_LOW);
  c_reserved_burst: cover property (burst_new &&
                                    burst_class == bpsc_pkg::CLASS_RESERVED);

endmodule : bpsc_capture

// [bench/bpsc_source_model.sv]
// Purpose: Far-end source that sends recovered words to the capture block.
// Assumes: One word per strobe, launched just after a rising clock edge.
// Notes:   Each idle() cycle toggles the data lines; between task calls the last driven value holds.
`timescale 1ns/10ps
`include "bpsc_defines.svh"

module bpsc_source_model (
  input  wire logic            clk,     // Word clock
  output bpsc_pkg::bpsc_word_s rx_word  // Word toward receiver
);

  initial rx_word = '{valid: 1'b0, data: 16'hFFFF};

  // ****************************************************************
  // Word level
  // ****************************************************************
  task automatic idle();
    @(posedge clk);
    rx_word <= '{valid: 1'b0, data: ~rx_word.data};
  endtask : idle

  // Idle gaps show inverted data, so a sticky last word cannot pass.
  task automatic put(input logic [15:0] w, input int gap);
    repeat (gap) idle();
    @(posedge clk);
    rx_word <= '{valid: 1'b1, data: w};
  endtask : put

  // ****************************************************************
  // Burst header
  // ****************************************************************
  task automatic send_burst(input logic [15:0] t, l, input int gap);
    put(`BPSC_SYNC_FIRST, gap);
    put(`BPSC_SYNC_SECOND, gap);
    put(t, gap);
    put(l, gap);
    idle();
  endtask : send_burst

endmodule : bpsc_source_model

// [bench/burst_preamble_status_capture_tb_top.sv]
// Purpose: Self-checking bench for the burst preamble capture block.
// Assumes: Reads answer one cycle after the strobe; capture flags too.
// Notes:   Expected values are built here from the header words sent.
`timescale 1ns/10ps
`include "bpsc_defines.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end end

module burst_preamble_status_capture_tb_top;
  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  rd_en = 1'b0;
  logic [7:0]            rd_addr = 8'h00;
  logic [7:0]            rd_data;
  logic                  rd_valid, burst_new, burst_error, stream_nonzero;
  bpsc_pkg::bpsc_word_s  rx_word;
  bpsc_pkg::bpsc_class_e burst_class;
  int                    miscompares = 0;
  int                    total_checks = 0;
  logic [4:0]            codes [13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
    5'h05, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h10, 5'h1F};
  bpsc_pkg::bpsc_class_e cls [13] = '{bpsc_pkg::CLASS_NULL,
    bpsc_pkg::CLASS_OTHER, bpsc_pkg::CLASS_RESERVED, bpsc_pkg::CLASS_PAUSE,
    bpsc_pkg::CLASS_MPEG, bpsc_pkg::CLASS_MPEG, bpsc_pkg::CLASS_MPEG,
    bpsc_pkg::CLASS_MPEG_LOW_RATE, bpsc_pkg::CLASS_MPEG_LOW_RATE,
    bpsc_pkg::CLASS_RESERVED, bpsc_pkg::CLASS_OTHER,
    bpsc_pkg::CLASS_RESERVED, bpsc_pkg::CLASS_RESERVED};

  always #2 clk = ~clk;

  bpsc_capture i_dut (.clk(clk), .reset(reset), .rx_word(rx_word),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .burst_new(burst_new), .burst_class(burst_class),
    .burst_error(burst_error), .stream_nonzero(stream_nonzero));

  bpsc_source_model i_src (.clk(clk), .rx_word(rx_word));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk_reg(input logic [7:0] a, e);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", e, rd_data)
  endtask : chk_reg

  // Type bits 6:5 read as zero whatever the source sent.
  task automatic chk_all(input logic [15:0] t, l);
    chk_reg(`BPSC_ADDR_TYPE_HIGH, t[15:8]);
    chk_reg(`BPSC_ADDR_TYPE_LOW, {t[7], 2'b00, t[4:0]});
    chk_reg(`BPSC_ADDR_LEN_HIGH, l[15:8]);
    chk_reg(`BPSC_ADDR_LEN_LOW, l[7:0]);
  endtask : chk_all

  task automatic burst(input logic [15:0] t, l, input int gap,
                       input bpsc_pkg::bpsc_class_e c);
    i_src.send_burst(t, l, gap);
    #1;
    `CHK("burst_new", 1'b1, burst_new)
    `CHK("class", c, burst_class)
    `CHK("error", t[7], burst_error)
    `CHK("stream", |t[15:13], stream_nonzero)
    @(posedge clk);
    #1;
    `CHK("new pulse end", 1'b0, burst_new)
    chk_all(t, l);
  endtask : burst

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin : watchdog
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial begin : main
    logic [7:0] k;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    chk_all(16'h0000, 16'h0000);
    `CHK("reset class", bpsc_pkg::CLASS_NULL, burst_class)
    burst(16'h1FE5, 16'h1234, 0, bpsc_pkg::CLASS_MPEG);
    for (int i = 0; i < 13; i++) begin
      k = 8'(i);
      burst({k[2:0], 5'h15, k[0], 2'b11, codes[i]}, {k, ~k}, i % 3,
            cls[i]);
    end
    // A repeated first sync word still waits for the second one.
    i_src.put(`BPSC_SYNC_FIRST, 0);
    i_src.put(`BPSC_SYNC_FIRST, 0);
    i_src.put(`BPSC_SYNC_SECOND, 1);
    i_src.put(16'h0007, 0);
    i_src.put(16'h0100, 2);
    i_src.idle();
    repeat (2) @(posedge clk);
    chk_all(16'h0007, 16'h0100);
    // A foreign word between the sync words breaks the header.
    i_src.put(`BPSC_SYNC_FIRST, 0);
    i_src.put(16'h1234, 0);
    i_src.put(`BPSC_SYNC_SECOND, 0);
    i_src.put(16'h0005, 0);
    i_src.put(16'h0200, 0);
    i_src.idle();
    repeat (2) @(posedge clk);
    chk_all(16'h0007, 16'h0100);
    chk_reg(8'h28, 8'h00);
    chk_reg(8'h2D, 8'h00);
    final_report();
  end

endmodule : burst_preamble_status_capture_tb_top
